// file: rtl/rtcc_defs.svh
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTCC_OFF_TIME      6'h00
`define RTCC_OFF_DATE      6'h04
`define RTCC_OFF_CTRL      6'h08

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RTCC_TIME_RST      32'h00000000
`define RTCC_DATE_RST      32'h00002101
`define RTCC_CTRL_RST      32'h00000000
`define RTCC_TIME_MASK     32'h007F7F7F
`define RTCC_DATE_MASK     32'h00FFFF3F
`define RTCC_CTRL_MASK     32'h00005D7F
`define RTCC_CTRL_INITONLY 32'h000000D0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTCC_SEC_U_LO      0
`define RTCC_SEC_T_LO      4
`define RTCC_MIN_U_LO      8
`define RTCC_MIN_T_LO      12
`define RTCC_HR_U_LO       16
`define RTCC_HR_T_LO       20
`define RTCC_PM_BIT        22
`define RTCC_DAY_U_LO      0
`define RTCC_DAY_T_LO      4
`define RTCC_MON_U_LO      8
`define RTCC_MON_T_BIT     12
`define RTCC_WDAY_LO       13
`define RTCC_YR_U_LO       16
`define RTCC_YR_T_LO       20
`define RTCC_BIT_STAMP_EDGE 3
`define RTCC_BIT_REF_DET   4
`define RTCC_BIT_BYPASS    5
`define RTCC_BIT_HOUR_FMT  6
`define RTCC_BIT_ALARM_ON  8
`define RTCC_BIT_WUT_ON    10
`define RTCC_BIT_STAMP_ON  11
`define RTCC_BIT_ALARM_IRQ 12
`define RTCC_BIT_WUT_IRQ   14
`define RTCC_BIT_SUMMER    16
`define RTCC_BIT_WINTER    17

// ----------------------------------------
// Timing
// ----------------------------------------
`define RTCC_SHADOW_PERIOD 2

`endif

// file: rtl/rtcc_pkg.sv
package rtcc_pkg;
   typedef logic [31:0] rtcc_word_t;
   typedef logic [5:0]  rtcc_addr_t;
   typedef enum logic [2:0] {
      RTCC_ADJ_IDLE   = 3'b001,
      RTCC_ADJ_SUMMER = 3'b010,
      RTCC_ADJ_WINTER = 3'b100
   } rtcc_adj_t;
endpackage

// file: rtl/rtcc_regs.sv
`timescale 1ns/10ps
`include "rtcc_defs.svh"
// Notes on behaviour
// - Time/date writes need init mode, unprotected
// - Seconds BCD units 3:0, tens 6:4
// - Minutes BCD units 11:8, tens 14:12
// - Hours BCD units 19:16, tens 21:20
// - Bit 22 marks PM
// - Day BCD units 3:0, tens 5:4
// - Month BCD units 11:8, tens 12
// - Weekday code in bits 15:13
// - Year BCD units 19:16, tens 23:20
// - Control bits 6,4 writable only in init; bit 7 is not writable
// - Summer/winter adjust applies at next second
// - Control writes ignored while protected
// - Wake-up clock divides by 8,4,2,1
// - Codes 1xx pick second tick, 11x adds 2^16
// - Bit 3 picks timestamp edge
// - Bit 4 enables reference clock detection
// - Bit 5 selects shadow or live reads
// - Bit 6 selects 12-hour format
// - Bits 8,10,11 enable alarm, wake-up, stamp
// - Bits 12,14 gate alarm and wake-up irqs
// - Summer adjust outside init adds one hour
module rtcc_regs (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            rstn,
   // Register bus
   input  wire rtcc_pkg::rtcc_addr_t reg_addr,
   input  wire rtcc_pkg::rtcc_word_t reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output rtcc_pkg::rtcc_word_t reg_rdata,
   // Mode levels, second tick and live counters
   input  wire logic            init_mode,
   input  wire logic            write_protect,
   input  wire logic            second_tick,
   input  wire rtcc_pkg::rtcc_word_t live_time,
   input  wire rtcc_pkg::rtcc_word_t live_date,
   // Stored calendar words and load pulses
   output rtcc_pkg::rtcc_word_t time_value,
   output rtcc_pkg::rtcc_word_t date_value,
   output logic                 time_load,
   output logic                 date_load,
   // Control field decode
   output logic [2:0]           wakeup_clock_choice,
   output logic                 wakeup_reload_add,
   output logic                 wakeup_tick_sel,
   output logic [1:0]           wakeup_div_log2,
   output logic                 stamp_edge_choice,
   output logic                 ref_clock_detect_on,
   output logic                 bypass_shadow_read,
   output logic                 hour_format_select,
   output logic                 alarm_on,
   output logic                 wakeup_timer_on,
   output logic                 stamp_capture_on,
   output logic                 alarm_irq_on,
   output logic                 wakeup_irq_on,
   // Event requests and gated interrupt lines
   input  wire logic            alarm_event,
   input  wire logic            wakeup_event,
   output logic                 alarm_irq,
   output logic                 wakeup_irq
);
   import rtcc_pkg::*;

   // ----------------------------------------
   // Write-side field split of the bus word
   // ----------------------------------------
   // Time digits picked from the bus word
   wire [3:0] seconds_units = reg_wdata[`RTCC_SEC_U_LO +: 4];
   wire [2:0] seconds_tens  = reg_wdata[`RTCC_SEC_T_LO +: 3];
   wire [3:0] minutes_units = reg_wdata[`RTCC_MIN_U_LO +: 4];
   wire [2:0] minutes_tens  = reg_wdata[`RTCC_MIN_T_LO +: 3];
   wire [3:0] hours_units   = reg_wdata[`RTCC_HR_U_LO +: 4];
   wire [1:0] hours_tens    = reg_wdata[`RTCC_HR_T_LO +: 2];
   wire       pm_marker     = reg_wdata[`RTCC_PM_BIT];

   // Date digits picked from the bus word
   wire [3:0] day_units     = reg_wdata[`RTCC_DAY_U_LO +: 4];
   wire [1:0] day_tens      = reg_wdata[`RTCC_DAY_T_LO +: 2];
   wire [3:0] month_units   = reg_wdata[`RTCC_MON_U_LO +: 4];
   wire       month_tens    = reg_wdata[`RTCC_MON_T_BIT];
   wire [2:0] weekday_code  = reg_wdata[`RTCC_WDAY_LO +: 3];
   wire [3:0] year_units    = reg_wdata[`RTCC_YR_U_LO +: 4];
   wire [3:0] year_tens     = reg_wdata[`RTCC_YR_T_LO +: 4];

   // Reassembled words, reserved positions forced to zero
   wire [31:0] time_wr_word = {9'h000, pm_marker, hours_tens, hours_units, 1'h0,
                               minutes_tens, minutes_units, 1'h0, seconds_tens,
                               seconds_units};
   wire [31:0] date_wr_word = {8'h00, year_tens, year_units, weekday_code,
                               month_tens, month_units, 2'h0, day_tens,
                               day_units};

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   rtcc_word_t time_reg, time_next;
   rtcc_word_t date_reg, date_next;
   rtcc_word_t ctrl_reg, ctrl_next;
   rtcc_word_t shadow_time_reg;
   rtcc_word_t shadow_date_reg;
   logic       shadow_phase_reg;
   rtcc_adj_t  adj_reg, adj_next;
   rtcc_word_t rdata_reg, rdata_next;

   // ----------------------------------------
   // Address decode and write qualification
   // ----------------------------------------
   wire hit_time   = (reg_addr == `RTCC_OFF_TIME);
   wire hit_date   = (reg_addr == `RTCC_OFF_DATE);
   wire hit_ctrl   = (reg_addr == `RTCC_OFF_CTRL);
   wire unlocked   = ~write_protect;
   wire cal_wr_ok  = reg_wr & init_mode & unlocked;
   wire wr_time    = cal_wr_ok & hit_time;
   wire wr_date    = cal_wr_ok & hit_date;
   wire wr_ctrl    = reg_wr & hit_ctrl & unlocked;
   // Init-only bits keep their old value outside init mode
   // Bits any unprotected write may change
   wire [31:0] ctrl_open_bits = `RTCC_CTRL_MASK & ~`RTCC_CTRL_INITONLY;
   // Bits that only follow the bus in init mode
   wire [31:0] ctrl_init_bits = `RTCC_CTRL_MASK & `RTCC_CTRL_INITONLY;
   wire [31:0] ctrl_wmask = init_mode ? (ctrl_open_bits | ctrl_init_bits)
                                      : ctrl_open_bits;
   wire summer_req = wr_ctrl & reg_wdata[`RTCC_BIT_SUMMER] & ~init_mode;
   wire winter_req = wr_ctrl & reg_wdata[`RTCC_BIT_WINTER] & ~init_mode;

   // ----------------------------------------
   // BCD hour arithmetic for seasonal change
   // ----------------------------------------
   // Pending request kinds
   wire adj_summer = (adj_reg == RTCC_ADJ_SUMMER);
   wire adj_winter = (adj_reg == RTCC_ADJ_WINTER);
   wire adj_idle   = (adj_reg == RTCC_ADJ_IDLE);
   wire [3:0] hr_u = time_reg[`RTCC_HR_U_LO +: 4];
   wire [1:0] hr_t = time_reg[`RTCC_HR_T_LO +: 2];
   // Tens digit widened before the product so no carry is lost
   wire [5:0] hr_bin = ({4'h0, hr_t} * 6'h0A) + {2'h0, hr_u};
   wire [5:0] hr_max = ctrl_reg[`RTCC_BIT_HOUR_FMT] ? 6'h0C : 6'h17;
   wire [5:0] hr_min = ctrl_reg[`RTCC_BIT_HOUR_FMT] ? 6'h01 : 6'h00;
   wire [5:0] hr_up  = (hr_bin == hr_max) ? hr_min : hr_bin + 6'h01;
   wire [5:0] hr_dn  = hr_bin - 6'h01;
   wire [5:0] hr_new = adj_summer ? hr_up : hr_dn;
   wire [1:0] hr_new_t = 2'(hr_new / 6'h0A);
   wire [3:0] hr_new_u = 4'(hr_new % 6'h0A);
   // Twelve-hour roll from 11 to 12 flips the meridiem
   wire pm_flip = ctrl_reg[`RTCC_BIT_HOUR_FMT] & adj_summer
                  & (hr_bin == 6'h0B);
   wire adj_fire = second_tick & ~adj_idle;
   wire winter_void = adj_winter & (hr_bin == 6'h00);

   // ----------------------------------------
   // Next-state for calendar registers
   // ----------------------------------------
   always_comb begin
      time_next = time_reg;
      if (wr_time) begin
         time_next = time_wr_word;
      end else if (adj_fire && !winter_void) begin
         time_next[`RTCC_HR_U_LO +: 4] = hr_new_u;
         time_next[`RTCC_HR_T_LO +: 2] = hr_new_t;
         time_next[`RTCC_PM_BIT] = time_reg[`RTCC_PM_BIT] ^ pm_flip;
      end
   end

   // Date fields stored as written
   always_comb begin
      date_next = date_reg;
      if (wr_date) begin
         date_next = date_wr_word;
      end
   end

   // Control register merge
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = (ctrl_reg & ~ctrl_wmask) | (reg_wdata & ctrl_wmask);
      end
   end

   // Seasonal adjustment request held until the next second
   always_comb begin
      adj_next = adj_reg;
      if (summer_req) begin
         adj_next = RTCC_ADJ_SUMMER;
      end else if (winter_req) begin
         adj_next = RTCC_ADJ_WINTER;
      end else if (adj_fire) begin
         adj_next = RTCC_ADJ_IDLE;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   wire bypass = ctrl_reg[`RTCC_BIT_BYPASS];
   wire [31:0] rd_time = bypass ? (live_time & `RTCC_TIME_MASK) : shadow_time_reg;
   wire [31:0] rd_date = bypass ? (live_date & `RTCC_DATE_MASK) : shadow_date_reg;

   // Read data select, zero when no read
   always_comb begin
      rdata_next = 32'h00000000;
      if (reg_rd) begin
         if (hit_time) begin
            rdata_next = rd_time;
         end else if (hit_date) begin
            rdata_next = rd_date;
         end else if (hit_ctrl) begin
            rdata_next = ctrl_reg;
         end
      end
   end

   // ----------------------------------------
   // Flops
   // ----------------------------------------
   // Time word: bus load or seasonal step
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         time_reg <= `RTCC_TIME_RST;
      end else begin
         time_reg <= time_next;
      end
   end

   // Date word: bus load only
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         date_reg <= `RTCC_DATE_RST;
      end else begin
         date_reg <= date_next;
      end
   end

   // Control word
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `RTCC_CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Pending seasonal request
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         adj_reg <= RTCC_ADJ_IDLE;
      end else begin
         adj_reg <= adj_next;
      end
   end

   // Read data, standing one cycle after the strobe
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Shadow refresh phase, toggles every kernel cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         shadow_phase_reg <= 1'b0;
      end else begin
         shadow_phase_reg <= ~shadow_phase_reg;
      end
   end

   // Shadow copies taken every second kernel cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         shadow_time_reg <= `RTCC_TIME_RST;
         shadow_date_reg <= `RTCC_DATE_RST;
      end else if (shadow_phase_reg) begin
         shadow_time_reg <= time_reg;
         shadow_date_reg <= date_reg;
      end
   end

   // ----------------------------------------
   // Usage limits for software
   // ----------------------------------------
   // Control rewrites racing an hour carry may swallow it
   // Live calendar counters come from outside this block
   // Shadow copies trail the stored words by up to 2 cycles
   // Slow bus clocks need the bypass bit, or reads tear
   // Reference detection assumes a prescaler of 0x00FF
   // Timestamp edge changes belong to stamp-off periods
   // Summer request outranks winter when both are set
   // Summer and winter bits are never stored; read as 0
   // Winter at hour 0 is dropped together with its request
   // Twelve-hour winter from 1 lands on 0, uncorrected
   // Twelve-hour roll 11 to 12 flips the meridiem bit
   // Calendar write in the tick cycle wins over the step
   // Write protection also freezes the control register
   // Writes take one cycle; the bus never waits
   // Unmapped offsets read zero and ignore writes
   // Wake-up divider code is meaningful only off the tick

   // ----------------------------------------
   // Control decode
   // ----------------------------------------
   // Bus and calendar outputs
   assign reg_rdata           = rdata_reg;
   assign time_value          = time_reg;
   assign date_value          = date_reg;
   assign time_load           = wr_time;
   assign date_load           = wr_date;

   // Wake-up clock source
   assign wakeup_clock_choice = ctrl_reg[2:0];
   assign wakeup_tick_sel     = ctrl_reg[2];
   assign wakeup_reload_add   = ctrl_reg[2] & ctrl_reg[1];
   assign wakeup_div_log2     = 2'h3 - ctrl_reg[1:0];

   // Timestamp, reference and read mode
   assign stamp_edge_choice   = ctrl_reg[`RTCC_BIT_STAMP_EDGE];
   assign ref_clock_detect_on = ctrl_reg[`RTCC_BIT_REF_DET];
   assign bypass_shadow_read  = bypass;
   assign hour_format_select  = ctrl_reg[`RTCC_BIT_HOUR_FMT];

   // Function enables
   assign alarm_on            = ctrl_reg[`RTCC_BIT_ALARM_ON];
   assign wakeup_timer_on     = ctrl_reg[`RTCC_BIT_WUT_ON];
   assign stamp_capture_on    = ctrl_reg[`RTCC_BIT_STAMP_ON];

   // Interrupt gates
   assign alarm_irq_on        = ctrl_reg[`RTCC_BIT_ALARM_IRQ];
   assign wakeup_irq_on       = ctrl_reg[`RTCC_BIT_WUT_IRQ];

   // Event requests gated by function and interrupt enables
   assign alarm_irq  = alarm_event & alarm_on & alarm_irq_on;
   assign wakeup_irq = wakeup_event & wakeup_timer_on & wakeup_irq_on;
endmodule

// file: dv/rtcc_regs_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module rtcc_regs_mon (
   input wire logic                 core_clk,
   input wire logic                 rstn,
   input wire rtcc_pkg::rtcc_addr_t reg_addr,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire rtcc_pkg::rtcc_word_t reg_rdata,
   input wire logic                 init_mode,
   input wire logic                 write_protect,
   input wire logic                 time_load,
   input wire logic                 date_load,
   input wire logic [2:0]           wakeup_clock_choice,
   input wire logic                 wakeup_reload_add,
   input wire logic                 wakeup_tick_sel,
   input wire logic [1:0]           wakeup_div_log2,
   input wire logic                 ref_clock_detect_on,
   input wire logic                 hour_format_select,
   input wire logic                 alarm_on,
   input wire logic                 alarm_irq_on,
   input wire logic                 alarm_event,
   input wire logic                 alarm_irq
);
   import rtcc_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Control write and open-gate decode
   wire ctl_wr = reg_wr && reg_addr == 6'h08;
   wire open_w = reg_wr && init_mode && !write_protect;

   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h00000000; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read cycle");
   property p_tload; time_load == (open_w && reg_addr == 6'h00); endproperty
   a_tload: assert property (p_tload)
      else $error("time load gating wrong");
   property p_dload; date_load == (open_w && reg_addr == 6'h04); endproperty
   a_dload: assert property (p_dload)
      else $error("date load gating wrong");
   property p_prot; write_protect && ctl_wr |=> $stable({hour_format_select, alarm_on,
      alarm_irq_on, wakeup_clock_choice}); endproperty
   a_prot: assert property (p_prot)
      else $error("control changed while protected");
   property p_initb; ctl_wr && !init_mode |=>
      $stable({ref_clock_detect_on, hour_format_select}); endproperty
   a_initb: assert property (p_initb)
      else $error("init-only control bit changed");
   property p_tick; wakeup_tick_sel == wakeup_clock_choice[2] &&
      wakeup_reload_add == &wakeup_clock_choice[2:1]; endproperty
   a_tick: assert property (p_tick)
      else $error("wake-up tick decode wrong");
   property p_div; !wakeup_tick_sel |-> wakeup_div_log2 == 2'h3 - wakeup_clock_choice[1:0];
   endproperty
   a_div: assert property (p_div)
      else $error("wake-up divider decode wrong");
   property p_airq; alarm_irq == (alarm_event && alarm_on && alarm_irq_on); endproperty
   a_airq: assert property (p_airq)
      else $error("alarm irq gating wrong");
endmodule

bind rtcc_regs rtcc_regs_mon rtcc_regs_mon_i (.core_clk, .rstn, .reg_addr, .reg_wr,
   .reg_rd, .reg_rdata, .init_mode, .write_protect, .time_load, .date_load,
   .wakeup_clock_choice, .wakeup_reload_add, .wakeup_tick_sel, .wakeup_div_log2,
   .ref_clock_detect_on, .hour_format_select, .alarm_on, .alarm_irq_on, .alarm_event,
   .alarm_irq);

// file: dv/rtcc_regs_tb.sv
`timescale 1ns/10ps
module rtcc_regs_tb;
   import rtcc_pkg::*;
   logic       core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, init_mode = 1'b0;
   logic       write_protect = 1'b0, second_tick = 1'b0, alarm_event = 1'b0;
   logic       wakeup_event = 1'b0, time_load, date_load, wakeup_reload_add, wakeup_tick_sel;
   logic       stamp_edge_choice, ref_clock_detect_on, bypass_shadow_read, hour_format_select;
   logic       alarm_on, wakeup_timer_on, stamp_capture_on, alarm_irq_on, wakeup_irq_on;
   logic       alarm_irq, wakeup_irq;
   logic [2:0] wakeup_clock_choice;
   logic [1:0] wakeup_div_log2;
   rtcc_addr_t reg_addr = 6'h00;
   rtcc_word_t reg_wdata = 32'h0, live_time = 32'h00235959, live_date = 32'h0;
   rtcc_word_t reg_rdata, time_value, date_value;
   int         error_cnt = 0, total_checks = 0;

   rtcc_regs rtcc_regs_i (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .init_mode, .write_protect, .second_tick, .live_time, .live_date,
      .time_value, .date_value, .time_load, .date_load, .wakeup_clock_choice,
      .wakeup_reload_add, .wakeup_tick_sel, .wakeup_div_log2, .stamp_edge_choice,
      .ref_clock_detect_on, .bypass_shadow_read, .hour_format_select, .alarm_on,
      .wakeup_timer_on, .stamp_capture_on, .alarm_irq_on, .wakeup_irq_on, .alarm_event,
      .wakeup_event, .alarm_irq, .wakeup_irq);

   // ----------------------------------------
   // Clock, watchdog and bus tasks
   // ----------------------------------------
   initial forever #50 core_clk = ~core_clk;
   initial begin
      repeat (3000) @(posedge core_clk);
      error_cnt++;
      complete_run;
   end
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input rtcc_word_t got, input rtcc_word_t exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input rtcc_addr_t a, input rtcc_word_t d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input rtcc_addr_t a, input rtcc_word_t exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge core_clk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd(6'h00, 32'h0);
      rd(6'h04, 32'h00002101);
      rd(6'h08, 32'h0);
      rd(6'h0C, 32'h0);
   endtask
   task automatic t_time;
      wr(6'h00, 32'h00123456);
      init_mode <= 1'b1;
      write_protect <= 1'b1;
      wr(6'h04, 32'h00123456);
      cyc(4);
      chk(time_value ^ date_value, 32'h00002101);
      write_protect <= 1'b0;
      wr(6'h00, 32'hFFFFFFFF);
      wr(6'h04, 32'hFFFFFFFF);
      cyc(4);
      rd(6'h00, 32'h007F7F7F);
      rd(6'h04, 32'h00FFFF3F);
      wr(6'h00, 32'h00100000);
      wr(6'h04, 32'h00A5E721);
      cyc(4);
      rd(6'h04, 32'h00A5E721);
   endtask
   task automatic t_ctrl;
      write_protect <= 1'b1;
      wr(6'h08, 32'hFFFCFFFF);
      rd(6'h08, 32'h0);
      write_protect <= 1'b0;
      init_mode <= 1'b0;
      wr(6'h08, 32'hFFFCFFFF);
      rd(6'h08, 32'h00005D2F);
      alarm_event <= 1'b1;
      wakeup_event <= 1'b1;
      init_mode <= 1'b1;
      wr(6'h08, 32'hFFFCFFFF);
      #1 chk({alarm_irq, wakeup_irq, stamp_edge_choice, ref_clock_detect_on,
         hour_format_select, alarm_on, wakeup_timer_on, stamp_capture_on}, 8'hFF);
      chk({31'h0, bypass_shadow_read}, 32'h1);
      @(posedge core_clk);
      rd(6'h00, 32'h00235959);
      wr(6'h08, 32'h0);
      #1 chk({alarm_irq, wakeup_irq, alarm_irq_on, wakeup_irq_on}, 4'h0);
      @(posedge core_clk);
      rd(6'h00, 32'h00100000);
   endtask
   task automatic t_wake;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(6'h08, {29'h0, c});
         #1 chk({wakeup_clock_choice, wakeup_tick_sel, wakeup_reload_add,
            c[2] ? 2'b00 : wakeup_div_log2},
            {c, c[2], c[2] & c[1], c[2] ? 2'b00 : 2'h3 - c[1:0]});
         @(posedge core_clk);
      end
   endtask
   task automatic t_adjust;
      init_mode <= 1'b0;
      wr(6'h08, 32'h00010000);
      cyc(3);
      chk(time_value, 32'h00100000);
      rd(6'h08, 32'h0);
      second_tick <= 1'b1;
      cyc(1);
      second_tick <= 1'b0;
      cyc(2);
      chk(time_value, 32'h00110000);
      wr(6'h08, 32'h00020000);
      second_tick <= 1'b1;
      cyc(1);
      second_tick <= 1'b0;
      cyc(2);
      chk(time_value, 32'h00100000);
   endtask

   initial begin
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset;
      t_time;
      t_ctrl;
      t_wake;
      t_adjust;
      complete_run;
   end
endmodule
